/* design/cdcl_top.sv */
// line-hold latch, hang-up tone and line-voltage disconnect, ring answer and indicators
`timescale 1ns/1ps
module cdcl_top #(
	parameter int TICK_CYCLES = cdcl_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// tone decoders, line sensor, ring detector
	input  wire logic       first_tone_decoder,
	input  wire logic       second_tone_decoder,
	input  wire logic       line_voltage_rise,
	input  wire logic       ring_detect,
	input  wire logic       ring_detector_fitted,
	// divert switch and remote contact
	input  wire logic       divert_switch,
	input  wire logic       remote_contact,
	// settings
	input  wire logic       remote_contact_type_select,
	input  wire logic       line_drop_on_hangup_enable,
	input  wire logic       auto_answer_enable,
	input  wire logic       tone_count_select,
	input  wire logic       tone_cadence_select,
	input  wire logic       tone_burst_length_select,
	input  wire logic       hangup_tone_detect_enable,
	input  wire logic [2:0] ring_count_preset,
	// power-up self test result
	input  wire logic       selftest_done,
	input  wire logic [2:0] selftest_error_code,
	// signal activity and levels
	input  wire logic       tx_active,
	input  wire logic       rx_active,
	input  wire logic [3:0] rx_level,
	input  wire logic [3:0] tx_level,
	// line hold and indicators
	output logic            line_hold,
	output logic            line_hold_indicator,
	output logic            status_indicator,
	output logic            transmit_indicator,
	output logic            receive_indicator,
	output logic [9:0]      rx_bar,
	output logic [9:0]      tx_bar,
	// failing device exercise request
	output logic            fault_exercise,
	output logic [2:0]      fault_exercise_code
);
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
		$error("cdcl_top: TICK_CYCLES out of range");
	end

	// thermometer decode of a level onto the bar segments
	function automatic logic [9:0] bar_decode(input logic [3:0] lvl);
		logic [9:0] b;
		b = '0;
		for (int i = 0; i < cdcl_pkg::BAR_SEGS; i++) begin
			b[i] = (4'(i) < lvl);
		end
		return b;
	endfunction

	// input synchronisers
	logic [cdcl_pkg::IN_W-1:0] in_s;
	cdcl_sync #(.WIDTH(cdcl_pkg::IN_W)) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     ({ring_detect, remote_contact, divert_switch,
		            line_voltage_rise, second_tone_decoder, first_tone_decoder}),
		.dout    (in_s)
	);

	logic                      tone_a;
	logic                      tone_b;
	assign tone_a = in_s[cdcl_pkg::IN_TONE_A];
	assign tone_b = in_s[cdcl_pkg::IN_TONE_B];

	// state registers
	logic [15:0]               div_ff, nxt_div;
	logic                      tick_ff, nxt_tick;
	logic [cdcl_pkg::IN_W-1:0] prev_ff, nxt_prev;
	logic                      hold_ff, nxt_hold;
	logic [15:0]               tone_ms_ff, nxt_tone_ms;
	logic [15:0]               gap_ms_ff, nxt_gap_ms;
	logic [2:0]                ring_cnt_ff, nxt_ring_cnt;
	logic [15:0]               ring_idle_ff, nxt_ring_idle;
	cdcl_pkg::cdcl_state_t     st_ff, nxt_st;
	logic [2:0]                err_ff, nxt_err;
	logic [2:0]                flash_n_ff, nxt_flash_n;
	logic [15:0]               phase_ms_ff, nxt_phase_ms;
	logic [15:0]               total_ms_ff, nxt_total_ms;
	logic                      hold_ind_ff, status_ff, tx_ind_ff, rx_ind_ff, exer_ff;
	logic [9:0]                rx_bar_ff, tx_bar_ff;

	// edges and combined conditions
	logic [cdcl_pkg::IN_W-1:0] rise, fall;
	logic                      tone_now, tone_release, volt_release;
	logic                      sw_toggle, rem_set, rem_clr, ring_seize;
	logic [2:0]                ring_target;
	logic [15:0]               tone_need;

	always_comb begin
		rise = in_s & ~prev_ff;
		fall = ~in_s & prev_ff;
		tone_now = tone_count_select ? (tone_a | tone_b) : (tone_a & tone_b);
		tone_need = tone_burst_length_select ? cdcl_pkg::TONE_LONG_MS : cdcl_pkg::TONE_SHORT_MS;
		tone_release = hangup_tone_detect_enable && hold_ff && (tone_ms_ff >= tone_need);
		volt_release = line_drop_on_hangup_enable && rise[cdcl_pkg::IN_LINE_RISE];
		sw_toggle = rise[cdcl_pkg::IN_DIVERT];
		// momentary: each closure toggles; permanent: contact level drives the latch
		rem_set = remote_contact_type_select ? rise[cdcl_pkg::IN_REMOTE] && !hold_ff
		                                     : rise[cdcl_pkg::IN_REMOTE];
		rem_clr = remote_contact_type_select ? rise[cdcl_pkg::IN_REMOTE] && hold_ff
		                                     : fall[cdcl_pkg::IN_REMOTE];
		if (ring_count_preset < cdcl_pkg::RING_MIN) begin
			ring_target = cdcl_pkg::RING_MIN;
		end else if (ring_count_preset > cdcl_pkg::RING_MAX) begin
			ring_target = cdcl_pkg::RING_MAX;
		end else begin
			ring_target = ring_count_preset;
		end
		ring_seize = auto_answer_enable && ring_detector_fitted && !hold_ff
		             && rise[cdcl_pkg::IN_RING] && (ring_cnt_ff + 3'h1 >= ring_target);
	end

	// millisecond tick, latch, tone and ring timing
	always_comb begin
		nxt_prev = in_s;
		nxt_tick = 1'b0;
		nxt_div = div_ff + 16'h0001;
		if (div_ff >= 16'(TICK_CYCLES - 1)) begin
			nxt_div = '0;
			nxt_tick = 1'b1;
		end
		// latch: a voltage or tone release wins over a set in the same cycle
		nxt_hold = hold_ff;
		if (sw_toggle) begin
			nxt_hold = !hold_ff;
		end else if (rem_set || ring_seize) begin
			nxt_hold = 1'b1;
		end else if (rem_clr) begin
			nxt_hold = 1'b0;
		end
		if (volt_release || tone_release) begin
			nxt_hold = 1'b0;
		end
		// tone timer: continuous needs unbroken tone, pulsed bridges short gaps
		nxt_tone_ms = tone_ms_ff;
		nxt_gap_ms = gap_ms_ff;
		if (!hold_ff || !hangup_tone_detect_enable || tone_release) begin
			nxt_tone_ms = '0;
			nxt_gap_ms = '0;
		end else if (tone_now) begin
			nxt_gap_ms = '0;
			if (tick_ff && tone_ms_ff != 16'hffff) nxt_tone_ms = tone_ms_ff + 16'h0001;
		end else if (!tone_cadence_select) begin
			nxt_tone_ms = '0;
		end else if (tick_ff) begin
			if (gap_ms_ff >= cdcl_pkg::PULSE_GAP_MS) begin
				nxt_tone_ms = '0;
			end else begin
				nxt_gap_ms = gap_ms_ff + 16'h0001;
				if (tone_ms_ff != '0) nxt_tone_ms = tone_ms_ff + 16'h0001;
			end
		end
		// ring burst counter, forgotten after a quiet spell
		nxt_ring_cnt = ring_cnt_ff;
		nxt_ring_idle = ring_idle_ff;
		if (hold_ff || !auto_answer_enable || !ring_detector_fitted) begin
			nxt_ring_cnt = '0;
			nxt_ring_idle = '0;
		end else if (rise[cdcl_pkg::IN_RING]) begin
			nxt_ring_cnt = ring_seize ? 3'h0 : ring_cnt_ff + 3'h1;
			nxt_ring_idle = '0;
		end else if (tick_ff && ring_cnt_ff != '0) begin
			nxt_ring_idle = ring_idle_ff + 16'h0001;
			if (ring_idle_ff >= cdcl_pkg::RING_IDLE_MS) begin
				nxt_ring_cnt = '0;
				nxt_ring_idle = '0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff       <= '0;
			tick_ff      <= 1'b0;
			prev_ff      <= '0;
			hold_ff      <= 1'b0;
			tone_ms_ff   <= '0;
			gap_ms_ff    <= '0;
			ring_cnt_ff  <= '0;
			ring_idle_ff <= '0;
		end else begin
			div_ff       <= nxt_div;
			tick_ff      <= nxt_tick;
			prev_ff      <= nxt_prev;
			hold_ff      <= nxt_hold;
			tone_ms_ff   <= nxt_tone_ms;
			gap_ms_ff    <= nxt_gap_ms;
			ring_cnt_ff  <= nxt_ring_cnt;
			ring_idle_ff <= nxt_ring_idle;
		end
	end

	// power-up error flash sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_err = err_ff;
		nxt_flash_n = flash_n_ff;
		nxt_phase_ms = (tick_ff) ? phase_ms_ff + 16'h0001 : phase_ms_ff;
		nxt_total_ms = (tick_ff && st_ff != cdcl_pkg::ST_WAIT && st_ff != cdcl_pkg::ST_OK
		                && st_ff != cdcl_pkg::ST_EXERCISE) ? total_ms_ff + 16'h0001 : total_ms_ff;
		case (st_ff)
			cdcl_pkg::ST_WAIT: begin
				nxt_phase_ms = '0;
				if (selftest_done) begin
					nxt_err = selftest_error_code;
					if (selftest_error_code >= cdcl_pkg::ERR_FIRST && selftest_error_code <= cdcl_pkg::ERR_LAST) begin
						nxt_st = cdcl_pkg::ST_FLASH_ON;
						nxt_flash_n = 3'h1;
					end else begin
						nxt_st = cdcl_pkg::ST_OK;
					end
				end
			end
			cdcl_pkg::ST_FLASH_ON: begin
				if (phase_ms_ff >= cdcl_pkg::FLASH_ON_MS) begin
					nxt_st = cdcl_pkg::ST_FLASH_OFF;
					nxt_phase_ms = '0;
				end
			end
			cdcl_pkg::ST_FLASH_OFF: begin
				if (phase_ms_ff >= cdcl_pkg::FLASH_OFF_MS) begin
					nxt_phase_ms = '0;
					if (flash_n_ff >= err_ff) begin
						nxt_st = cdcl_pkg::ST_PAUSE;
					end else begin
						nxt_st = cdcl_pkg::ST_FLASH_ON;
						nxt_flash_n = flash_n_ff + 3'h1;
					end
				end
			end
			cdcl_pkg::ST_PAUSE: begin
				if (total_ms_ff >= cdcl_pkg::FLASH_TOTAL_MS) begin
					nxt_st = cdcl_pkg::ST_EXERCISE;
				end else if (phase_ms_ff >= cdcl_pkg::FLASH_PAUSE_MS) begin
					nxt_st = cdcl_pkg::ST_FLASH_ON;
					nxt_flash_n = 3'h1;
					nxt_phase_ms = '0;
				end
			end
			cdcl_pkg::ST_OK, cdcl_pkg::ST_EXERCISE: begin
				nxt_phase_ms = '0;
			end
			default: begin
				nxt_st = cdcl_pkg::ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff       <= cdcl_pkg::ST_WAIT;
			err_ff      <= cdcl_pkg::ERR_NONE;
			flash_n_ff  <= '0;
			phase_ms_ff <= '0;
			total_ms_ff <= '0;
		end else begin
			st_ff       <= nxt_st;
			err_ff      <= nxt_err;
			flash_n_ff  <= nxt_flash_n;
			phase_ms_ff <= nxt_phase_ms;
			total_ms_ff <= nxt_total_ms;
		end
	end

	// registered indicator outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_ind_ff <= 1'b0;
			status_ff   <= 1'b0;
			tx_ind_ff   <= 1'b0;
			rx_ind_ff   <= 1'b0;
			exer_ff     <= 1'b0;
			rx_bar_ff   <= '0;
			tx_bar_ff   <= '0;
		end else begin
			hold_ind_ff <= nxt_hold;
			status_ff   <= (nxt_st != cdcl_pkg::ST_FLASH_OFF) && (nxt_st != cdcl_pkg::ST_PAUSE);
			tx_ind_ff   <= tx_active;
			rx_ind_ff   <= rx_active;
			exer_ff     <= (nxt_st == cdcl_pkg::ST_EXERCISE);
			rx_bar_ff   <= bar_decode(rx_level);
			tx_bar_ff   <= bar_decode(tx_level);
		end
	end

	assign line_hold           = hold_ff;
	assign line_hold_indicator = hold_ind_ff;
	assign status_indicator    = status_ff;
	assign transmit_indicator  = tx_ind_ff;
	assign receive_indicator   = rx_ind_ff;
	assign rx_bar              = rx_bar_ff;
	assign tx_bar              = tx_bar_ff;
	assign fault_exercise      = exer_ff;
	assign fault_exercise_code = err_ff;
endmodule

/* design/cdcl_pkg.sv */
// constants and types shared by the call disconnect control block
package cdcl_pkg;
	// clock and time base
	localparam int CLK_HZ          = 40_000_000;
	localparam int TICK_MS         = 1;
	localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_W            = 16;
	// tone qualification and ring idle times, milliseconds
	localparam logic [15:0] TONE_LONG_MS   = 16'h0fa0; // 4 s
	localparam logic [15:0] TONE_SHORT_MS  = 16'h07d0; // 2 s
	localparam logic [15:0] PULSE_GAP_MS   = 16'h03e8; // longest silence inside a pulsed tone
	localparam logic [15:0] RING_IDLE_MS   = 16'h1f40; // ring burst count forgotten after this
	// status flash timing, milliseconds
	localparam logic [15:0] FLASH_ON_MS    = 16'h00fa;
	localparam logic [15:0] FLASH_OFF_MS   = 16'h00fa;
	localparam logic [15:0] FLASH_PAUSE_MS = 16'h03e8;
	localparam logic [15:0] FLASH_TOTAL_MS = 16'hea60; // one minute
	// self-test error codes, equal to the flash count
	localparam logic [2:0] ERR_NONE        = 3'h0;
	localparam logic [2:0] ERR_FIRST       = 3'h3;
	localparam logic [2:0] ERR_LAST        = 3'h6;
	// ring burst preset range
	localparam logic [2:0] RING_MIN        = 3'h1;
	localparam logic [2:0] RING_MAX        = 3'h5;
	// bar graph
	localparam int BAR_SEGS        = 10;
	localparam int LVL_W           = 4;
	// synchroniser lane positions
	localparam int IN_W            = 6;
	localparam int IN_TONE_A       = 0;
	localparam int IN_TONE_B       = 1;
	localparam int IN_LINE_RISE    = 2;
	localparam int IN_DIVERT       = 3;
	localparam int IN_REMOTE       = 4;
	localparam int IN_RING         = 5;
	// status indicator sequencer
	typedef enum logic [2:0] {
		ST_WAIT      = 3'b000,
		ST_OK        = 3'b001,
		ST_FLASH_ON  = 3'b010,
		ST_FLASH_OFF = 3'b011,
		ST_PAUSE     = 3'b100,
		ST_EXERCISE  = 3'b101
	} cdcl_state_t;
endpackage

/* design/cdcl_sync.sv */
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module cdcl_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// raw and synchronised levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// first stage feeds only the second stage
	always_comb begin
		nxt_meta = din;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign dout = sync_ff;
endmodule

/* testbench/cdcl_sva.sv */
// port assertions for the call disconnect control block
`timescale 1ns/1ps
module cdcl_sva #(
	parameter int TICK_CYCLES = 4
) (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// watched inputs
	input wire logic       line_voltage_rise,
	input wire logic       divert_switch,
	input wire logic       line_drop_on_hangup_enable,
	input wire logic       tx_active,
	input wire logic       rx_active,
	input wire logic [3:0] rx_level,
	input wire logic [3:0] tx_level,
	// watched outputs
	input wire logic       line_hold,
	input wire logic       line_hold_indicator,
	input wire logic       status_indicator,
	input wire logic       transmit_indicator,
	input wire logic       receive_indicator,
	input wire logic [9:0] rx_bar,
	input wire logic [9:0] tx_bar
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// thermometer code expected for a level
	function automatic logic [9:0] bar(input logic [3:0] l);
		for (int i = 0; i < 10; i++) bar[i] = (l > i);
	endfunction

	// indicators and bar graphs
	property p_ind; line_hold_indicator == line_hold; endproperty
	property p_tx; transmit_indicator == $past(tx_active); endproperty
	property p_rx; receive_indicator == $past(rx_active); endproperty
	property p_rbar; rx_bar == bar($past(rx_level)); endproperty
	property p_tbar; tx_bar == bar($past(tx_level)); endproperty
	// latch events and status flash
	property p_drop; $rose(line_voltage_rise) && line_drop_on_hangup_enable |-> ##4 !line_hold; endproperty
	property p_set; $rose(divert_switch) && !line_hold && !line_voltage_rise |-> ##4 line_hold; endproperty
	property p_flash; $fell(status_indicator) |-> !status_indicator [*8]; endproperty

	a_ind: assert property (p_ind) else $error("line hold indicator differs from latch");
	a_tx: assert property (p_tx) else $error("transmit indicator wrong");
	a_rx: assert property (p_rx) else $error("receive indicator wrong");
	a_rbar: assert property (p_rbar) else $error("receive bar wrong");
	a_tbar: assert property (p_tbar) else $error("transmit bar wrong");
	a_drop: assert property (p_drop) else $error("voltage rise did not release");
	a_set: assert property (p_set) else $error("divert press did not seize");
	a_flash: assert property (p_flash) else $error("flash off phase too short");

	// main scenarios reached
	c_seize: cover property ($rose(line_hold));
	c_free: cover property ($fell(line_hold));
	c_flash: cover property ($fell(status_indicator));
endmodule

bind cdcl_top cdcl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.sys_clk, .rst_n, .line_voltage_rise, .divert_switch,
	.line_drop_on_hangup_enable, .tx_active, .rx_active, .rx_level, .tx_level, .line_hold, .line_hold_indicator,
	.status_indicator, .transmit_indicator, .receive_indicator, .rx_bar, .tx_bar);

/* testbench/cdcl_far_model.sv */
// model of the tone decoders and ring detector
`timescale 1ns/1ps
module cdcl_far_model (
	// clock
	input wire logic       sys_clk,
	// tone commands: bit 0 first decoder, bit 1 second
	input wire logic [1:0] tone_sel,
	input wire logic       tone_pulsed,
	// detector outputs
	output logic           first_tone_decoder,
	output logic           second_tone_decoder,
	output logic           ring_detect
);
	int ph = 0;
	initial ring_detect = 1'b0;
	// pulsed tone 500 cycles on, 500 off; gaps stay below the pulsed-gap limit
	always @(negedge sys_clk) begin
		ph <= (tone_sel == 2'h0) ? 0 : (ph + 1) % 1000;
		first_tone_decoder <= tone_sel[0] && (!tone_pulsed || ph < 500);
		second_tone_decoder <= tone_sel[1] && (!tone_pulsed || ph < 500);
	end
	// ring bursts, one rising edge each
	task automatic ring(input int n);
		repeat (n) begin
			ring_detect = 1'b1;
			repeat (8) @(negedge sys_clk);
			ring_detect = 1'b0;
			repeat (8) @(negedge sys_clk);
		end
	endtask
endmodule

/* testbench/tb.sv */
// self-checking bench for the call disconnect control block
`timescale 1ns/1ps
module tb;
	logic       sys_clk = 0, rst_n = 0, line_voltage_rise = 0, ring_detector_fitted = 1, divert_switch = 0;
	logic       remote_contact = 0, remote_contact_type_select = 1, line_drop_on_hangup_enable = 1;
	logic       auto_answer_enable = 0, tone_count_select = 1, tone_cadence_select = 0, tone_burst_length_select = 0;
	logic       hangup_tone_detect_enable = 0, selftest_done = 0, tx_active = 0, rx_active = 0, tone_pulsed = 0;
	logic [2:0] ring_count_preset = 3'h1, selftest_error_code = 3'h0;
	logic [3:0] rx_level = 4'h0, tx_level = 4'h0;
	logic [1:0] tone_sel = 2'h0;
	logic       first_tone_decoder, second_tone_decoder, ring_detect, line_hold, line_hold_indicator;
	logic       status_indicator, transmit_indicator, receive_indicator, fault_exercise;
	logic [9:0] rx_bar, tx_bar;
	logic [2:0] fault_exercise_code;
	int         failures = 0, num_checks = 0, exp_hold = 0;
	// one clock per millisecond tick keeps the minute of flashing inside the run
	localparam int TK = 1;

	cdcl_top #(.TICK_CYCLES(TK)) DUT (.sys_clk, .rst_n, .first_tone_decoder, .second_tone_decoder,
		.line_voltage_rise, .ring_detect, .ring_detector_fitted, .divert_switch, .remote_contact,
		.remote_contact_type_select, .line_drop_on_hangup_enable, .auto_answer_enable, .tone_count_select,
		.tone_cadence_select, .tone_burst_length_select, .hangup_tone_detect_enable, .ring_count_preset,
		.selftest_done, .selftest_error_code, .tx_active, .rx_active, .rx_level, .tx_level, .line_hold,
		.line_hold_indicator, .status_indicator, .transmit_indicator, .receive_indicator, .rx_bar, .tx_bar,
		.fault_exercise, .fault_exercise_code);
	cdcl_far_model far (.sys_clk, .tone_sel, .tone_pulsed, .first_tone_decoder, .second_tone_decoder,
		.ring_detect);

	// 40 MHz clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic do_reset();
		rst_n = 0;
		cyc(20);
		rst_n = 1;
		exp_hold = 0;
		cyc(2);
	endtask
	// reference thermometer and random source
	function automatic logic [9:0] bar(input int l);
		for (int i = 0; i < 10; i++) bar[i] = (l > i);
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// divert press toggles the latch
	task automatic press();
		divert_switch = 1;
		cyc(5);
		divert_switch = 0;
		cyc(5);
		exp_hold = !exp_hold;
		check(line_hold, exp_hold);
	endtask
	// seize, play tone, expect release after ms or none when ms is 0
	task automatic tone(input logic [1:0] sel, input logic cnt, cad, pul, lng, en, input int ms);
		int i;
		tone_count_select = cnt;
		tone_cadence_select = cad;
		tone_burst_length_select = lng;
		hangup_tone_detect_enable = en;
		press();
		tone_sel = sel;
		tone_pulsed = pul;
		cyc(ms ? (ms - 60) * TK : 2150 * TK);
		check(line_hold, 1'b1);
		for (i = 0; i < 120 * TK && ms != 0 && line_hold !== 1'b0; i++) cyc(1);
		if (i == 120 * TK) begin
			failures++;
			conclude();
		end
		if (ms) exp_hold = 0;
		check(line_hold, exp_hold);
		tone_sel = 2'h0;
		cyc(8);
		if (exp_hold) press();
	endtask

	initial begin
		int n;
		logic prev;
		logic [31:0] r;
		r = 32'h57fa;
		cyc(20);
		check({line_hold, status_indicator}, 2'h0);
		rst_n = 1;
		cyc(2);
		check(status_indicator, 1'b1);
		// error flash count per code
		for (int c = 3; c < 7; c++) begin
			selftest_error_code = c[2:0];
			selftest_done = 1;
			n = 0;
			prev = 1;
			repeat ((c * 500 - 100) * TK) begin
				@(negedge sys_clk);
				if (prev && !status_indicator) n++;
				prev = status_indicator;
			end
			check(n, c);
			check(fault_exercise_code, c);
			// shortest code: about a minute of flashing, then steady status and exercise
			if (c == 3) begin
				n = 0;
				while (n < 62000 * TK && fault_exercise !== 1'b1) begin
					cyc(1);
					n++;
				end
				check({fault_exercise, status_indicator, n > 55000 * TK}, 3'h7);
				if (n == 62000 * TK) conclude();
			end
			// drop done first so the released sequencer cannot take the old code
			selftest_done = 0;
			do_reset();
		end
		selftest_done = 0;
		do_reset();
		$display("test flash done");
		// random levels and activity
		repeat (40) begin
			r = xs(r);
			{rx_active, tx_active, tx_level, rx_level} = r[9:0];
			cyc(2);
			check({rx_bar, tx_bar}, {bar(rx_level), bar(tx_level)});
			check({receive_indicator, transmit_indicator}, {rx_active, tx_active});
		end
		{rx_active, tx_active} = 2'h0;
		$display("test indicators done");
		press();
		press();
		// momentary then permanent remote contact
		for (int i = 0; i < 4; i++) begin
			remote_contact = !remote_contact;
			cyc(5);
			if (!i[0]) exp_hold = !exp_hold;
			check(line_hold, exp_hold);
		end
		remote_contact_type_select = 0;
		for (int i = 0; i < 2; i++) begin
			remote_contact = !remote_contact;
			cyc(5);
			exp_hold = remote_contact;
			check(line_hold, exp_hold);
		end
		$display("test remote done");
		// voltage rise honoured, then ignored
		for (int e = 1; e >= 0; e--) begin
			line_drop_on_hangup_enable = e[0];
			press();
			line_voltage_rise = 1;
			cyc(5);
			if (e) exp_hold = 0;
			check(line_hold, exp_hold);
			line_voltage_rise = 0;
			cyc(5);
		end
		press();
		line_drop_on_hangup_enable = 1;
		$display("test voltage done");
		// ring answer at each preset
		auto_answer_enable = 1;
		for (int p = 1; p < 6; p++) begin
			ring_count_preset = p[2:0];
			far.ring(p - 1);
			check(line_hold, 1'b0);
			far.ring(1);
			exp_hold = 1;
			check(line_hold, exp_hold);
			press();
		end
		auto_answer_enable = 0;
		far.ring(3);
		check(line_hold, 1'b0);
		auto_answer_enable = 1;
		ring_detector_fitted = 0;
		far.ring(3);
		check(line_hold, 1'b0);
		$display("test ring done");
		// hang-up tone cases
		tone(2'h1, 1, 0, 0, 0, 1, 2000);
		tone(2'h1, 0, 0, 0, 0, 1, 0);
		tone(2'h3, 0, 0, 0, 1, 1, 4000);
		tone(2'h2, 1, 1, 1, 0, 1, 2000);
		tone(2'h1, 1, 0, 1, 0, 1, 0);
		tone(2'h3, 1, 0, 0, 0, 0, 0);
		$display("test tone done");
		conclude();
	end
endmodule
